// file: design/hdlc_slice_pkg.sv
// Shared constants and register map of the HDLC address, timer and receive status slice
package hdlc_slice_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_COMMAND         = 8'h21;
  localparam logic [7:0] IDX_MODE            = 8'h22;
  localparam logic [7:0] IDX_TIMER_CONFIG    = 8'h23;
  localparam logic [7:0] IDX_TX_ADDR_FIRST   = 8'h24;
  localparam logic [7:0] IDX_TX_ADDR_SECOND  = 8'h25;
  localparam logic [7:0] IDX_RX_LENGTH_LOW   = 8'h25;
  localparam logic [7:0] IDX_RX_HIGH_FIRST   = 8'h26;
  localparam logic [7:0] IDX_RX_HIGH_SECOND  = 8'h27;
  localparam logic [7:0] IDX_RX_FRAME_STATUS = 8'h27;
  localparam logic [7:0] IDX_RX_LENGTH_HIGH  = 8'h28;
  // Reset values
  localparam logic [7:0] RESET_BYTE          = 8'h00;
  // Mode register fields
  localparam int MODE_OP_HI   = 7;
  localparam int MODE_OP_LO   = 6;
  localparam int MODE_ADDR16  = 5;
  localparam int MODE_TIMER   = 4;
  localparam int MODE_RTS     = 2;
  localparam int MODE_TRS     = 1;
  localparam int MODE_LOOP    = 0;
  // Command register fields
  localparam int CMD_START_TIMER = 0;
  // Timer register fields
  localparam int TIMER_CNT_HI = 7;
  localparam int TIMER_CNT_LO = 5;
  localparam int TIMER_VAL_HI = 4;
  localparam int TIMER_VAL_LO = 0;
  localparam logic [2:0] COUNT_UNLIMITED = 3'h7;
  // Timer prescale factors in transmit clock periods
  localparam int K_COARSE = 32768;
  localparam int K_FINE   = 512;
  localparam int EXT_SCALE_SHIFT = 5;
  // Receive high address fields
  localparam int RAH_CRI = 1;
  localparam int RAH_MCS = 1;
  localparam int ADDR_CR_BIT = 1;
  localparam logic [5:0] GROUP_ADDR_A = 6'h3f;
  localparam logic [5:0] GROUP_ADDR_B = 6'h3f & 6'h3f;
  localparam logic [7:0] GROUP_BYTE_A = 8'hfe;
  localparam logic [7:0] GROUP_BYTE_B = 8'hfc;
  // Match codes
  localparam logic [1:0] MATCH_FIRST  = 2'h2;
  localparam logic [1:0] MATCH_SECOND = 2'h0;
  localparam logic [1:0] MATCH_GROUP  = 2'h1;
  localparam logic [1:0] MATCH_NONE   = 2'h3;
  // Frame status fields
  localparam int ST_VALID    = 7;
  localparam int ST_OVERFLOW = 6;
  localparam int ST_CRC      = 5;
  localparam int ST_ABORT    = 4;
  localparam int ST_MATCH_HI = 3;
  localparam int ST_MATCH_LO = 2;
  localparam int ST_CR       = 1;
  // Minimum frame lengths in bytes
  localparam logic [11:0] MIN_LEN_ADDR16 = 12'd4;
  localparam logic [11:0] MIN_LEN_ADDR8  = 12'd3;
  localparam logic [11:0] MIN_LEN_TRANS1 = 12'd3;
  localparam logic [11:0] MIN_LEN_TRANS0 = 12'd2;
  localparam logic [11:0] MIN_LEN_EXT    = 12'd1;
  localparam logic [11:0] MAX_LEN        = 12'd4095;
  // Operating modes
  typedef enum logic [1:0] {
    OP_AUTO      = 2'b00,
    OP_NON_AUTO  = 2'b01,
    OP_TRANSP    = 2'b10,
    OP_EXT_TRANS = 2'b11
  } op_mode_e;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage : hdlc_slice_pkg

// file: design/protocol_timer.sv
// Protocol timer: t1 retry timer for auto-mode, t2/t1 interrupt timer for software use
module protocol_timer
  import hdlc_slice_pkg::*;
#(
  parameter int K_COARSE_P = K_COARSE,
  parameter int K_FINE_P   = K_FINE
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_tick,
  input  wire logic       i_fine,
  input  wire logic       i_internal,
  input  wire logic [2:0] i_count,
  input  wire logic [4:0] i_period,
  input  wire logic       i_start,
  input  wire logic       i_stop,
  input  wire logic       i_wait_ack,
  output logic            o_timer_event,
  output logic            o_send_supervisory,
  output logic            o_retries_done
);
  typedef struct packed {
    logic        run;
    logic        exhausted;
    logic [15:0] pre;
    logic [8:0]  per;
    logic [2:0]  retry;
    logic        event_p;
    logic        sup;
    logic        done;
  } timer_s;

  timer_s st;
  timer_s next_st;
  logic [15:0] k_last;
  logic [8:0]  target;

  always_comb
  begin
    next_st = st;
    next_st.event_p = 1'b0;
    next_st.sup = 1'b0;
    next_st.done = 1'b0;
    k_last = i_fine ? 16'(K_FINE_P - 1) : 16'(K_COARSE_P - 1);
    if (i_internal || i_count == COUNT_UNLIMITED)
      target = {4'h0, i_period};
    else
      target = 9'({i_count, 5'h00}) + {4'h0, i_period};
    if (i_stop)
    begin
      next_st.run = 1'b0;
      next_st.pre = '0;
      next_st.per = '0;
    end
    else if (i_internal)
    begin
      if (!i_wait_ack)
      begin
        next_st.run = 1'b0;
        next_st.exhausted = 1'b0;
        next_st.retry = '0;
      end
      else if (!st.run && !st.exhausted)
      begin
        next_st.run = 1'b1;
        next_st.pre = '0;
        next_st.per = '0;
      end
    end
    else if (i_start)
    begin
      next_st.run = 1'b1;
      next_st.pre = '0;
      next_st.per = '0;
    end
    if (!i_stop && st.run && i_tick && (i_wait_ack || !i_internal))
    begin
      next_st.pre = st.pre + 16'h0001;
      if (st.pre >= k_last)
      begin
        next_st.pre = '0;
        next_st.per = st.per + 9'h001;
        if (st.per >= target)
        begin
          next_st.per = '0;
          if (i_internal)
          begin
            if (i_count == COUNT_UNLIMITED)
              next_st.sup = 1'b1;
            else if (st.retry < i_count)
            begin
              next_st.sup = 1'b1;
              next_st.retry = st.retry + 3'h1;
            end
            else
            begin
              next_st.done = 1'b1;
              next_st.exhausted = 1'b1;
              next_st.run = 1'b0;
            end
          end
          else
          begin
            next_st.event_p = 1'b1;
            if (i_count != COUNT_UNLIMITED)
              next_st.run = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_timer_event      = st.event_p;
  assign o_send_supervisory = st.sup;
  assign o_retries_done     = st.done;
endmodule : protocol_timer

// file: design/hdlc_address_timer_rx_status.sv
// HDLC slice: RTS control, loopback, protocol timer, addresses and receive frame status
//
// Added by the designer: the AXI4-Lite register port.
module hdlc_address_timer_rx_status
  import hdlc_slice_pkg::*;
#(
  parameter int K_COARSE_P = K_COARSE,
  parameter int K_FINE_P   = K_FINE
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        i_tx_clk,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_rts_n,
  input  wire logic        i_bus_config,
  input  wire logic        i_tx_serial,
  input  wire logic        i_tx_frame_active,
  input  wire logic        i_tx_is_command,
  input  wire logic        i_wait_ack,
  output logic             o_rx_serial,
  input  wire logic        i_rx_byte_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_message_end_event,
  input  wire logic        i_rx_partial_bits,
  input  wire logic        i_rx_crc_ok,
  input  wire logic        i_rx_aborted,
  input  wire logic        i_rx_data_lost,
  output logic [1:0]       o_operating_mode_select,
  output logic             o_address_length_select,
  output logic             o_modulo_select,
  output logic             o_tx_address_enable,
  output logic [7:0]       o_tx_address_first,
  output logic [7:0]       o_tx_address_second,
  output logic             o_timer_event,
  output logic             o_send_supervisory,
  output logic             o_retries_done
);
  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_idx;
    logic        w_held;
    logic [7:0]  w_byte;
    logic        w_lane;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [7:0]  mode;
    logic [7:0]  timer_config;
    logic [7:0]  tx_address_first;
    logic [7:0]  tx_address_second;
    logic [7:0]  rx_high_address_first;
    logic [7:0]  rx_high_address_second;
    logic [11:0] rx_length;
    logic [7:0]  rx_frame_status;
    logic [11:0] byte_count;
    logic [7:0]  high_byte;
    logic        lost;
    logic        start_pulse;
    logic        stop_pulse;
    logic [2:0]  txclk_sync;
    logic [1:0]  rxd_sync;
    logic        txd;
    logic        rx_serial;
    logic        rts_n;
    logic        tx_addr_en;
    logic        modulo;
    logic [7:0]  tx_addr_first_out;
    logic [7:0]  tx_addr_second_out;
  } slice_s;

  slice_s st;
  slice_s next_st;
  op_mode_e    op_mode;
  logic        addr16;
  logic        high_recog;
  logic [11:0] min_len;
  logic [1:0]  match;
  logic [7:0]  cur_high;
  logic        cr_flag;
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        rd_ok;
  logic [7:0]  rd_val;

  always_comb
  begin
    next_st = st;
    op_mode = op_mode_e'(st.mode[MODE_OP_HI:MODE_OP_LO]);
    addr16  = st.mode[MODE_ADDR16];
    // Write channels taken independently, answered once both are held
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_held = 1'b1;
      next_st.w_byte = s_axi_wdata[7:0];
      next_st.w_lane = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    wr_fire = next_st.aw_held && next_st.w_held && !next_st.bvalid;
    wr_idx  = next_st.aw_idx;
    next_st.start_pulse = 1'b0;
    next_st.stop_pulse = 1'b0;
    if (wr_fire)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (wr_idx)
        IDX_COMMAND, IDX_MODE, IDX_TIMER_CONFIG, IDX_TX_ADDR_FIRST, IDX_TX_ADDR_SECOND,
        IDX_RX_HIGH_FIRST, IDX_RX_HIGH_SECOND:
        begin
        end
        default:
          next_st.bresp = RESP_DECERR;
      endcase
      if (next_st.w_lane)
      begin
        case (wr_idx)
          IDX_COMMAND:
            next_st.start_pulse = next_st.w_byte[CMD_START_TIMER];
          IDX_MODE:
            next_st.mode = next_st.w_byte;
          IDX_TIMER_CONFIG:
          begin
            next_st.timer_config = next_st.w_byte;
            next_st.stop_pulse = 1'b1;
          end
          IDX_TX_ADDR_FIRST:
            next_st.tx_address_first = next_st.w_byte;
          IDX_TX_ADDR_SECOND:
            next_st.tx_address_second = next_st.w_byte;
          IDX_RX_HIGH_FIRST:
            next_st.rx_high_address_first = next_st.w_byte;
          IDX_RX_HIGH_SECOND:
            next_st.rx_high_address_second = next_st.w_byte;
          default:
          begin
          end
        endcase
      end
    end
    // Readies drop while a write is held or answered
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;
    // Read channel
    rd_idx = s_axi_araddr[9:2];
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    case (rd_idx)
      IDX_MODE:            rd_val = st.mode;
      IDX_TIMER_CONFIG:    rd_val = st.timer_config;
      IDX_RX_LENGTH_LOW:   rd_val = st.rx_length[7:0];
      IDX_RX_FRAME_STATUS: rd_val = st.rx_frame_status;
      IDX_RX_LENGTH_HIGH:  rd_val = {4'h0, st.rx_length[11:8]};
      IDX_COMMAND, IDX_TX_ADDR_FIRST, IDX_RX_HIGH_FIRST:
        rd_val = 8'h00;
      default:
        rd_ok = 1'b0;
    endcase
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_DECERR;
    end
    next_st.arready = !next_st.rvalid;
    // Pin synchronisers, loopback and RTS
    next_st.txclk_sync = {st.txclk_sync[1:0], i_tx_clk};
    next_st.rxd_sync = {st.rxd_sync[0], i_rxd};
    next_st.txd = i_tx_serial;
    next_st.rx_serial = st.mode[MODE_LOOP] ? i_tx_serial : st.rxd_sync[1];
    if (st.mode[MODE_RTS] && !i_bus_config)
      next_st.rts_n = 1'b0;
    else
      next_st.rts_n = !i_tx_frame_active;
    // Transmit address bytes
    cr_flag = i_tx_is_command ? st.rx_high_address_first[RAH_CRI]
                              : !st.rx_high_address_first[RAH_CRI];
    next_st.tx_addr_en = (op_mode == OP_AUTO);
    next_st.modulo = (op_mode == OP_AUTO) && st.rx_high_address_second[RAH_MCS];
    next_st.tx_addr_first_out = st.tx_address_first;
    if (addr16)
      next_st.tx_addr_first_out[ADDR_CR_BIT] = cr_flag;
    next_st.tx_addr_second_out = st.tx_address_second;
    // Receive frame tracking
    high_recog = ((op_mode == OP_AUTO || op_mode == OP_NON_AUTO) && addr16)
                 || (op_mode == OP_TRANSP && addr16);
    cur_high = (i_rx_byte_valid && st.byte_count == 12'h000) ? i_rx_byte : st.high_byte;
    if (cur_high[7:2] == st.rx_high_address_first[7:2])
      match = MATCH_FIRST;
    else if (cur_high[7:2] == st.rx_high_address_second[7:2])
      match = MATCH_SECOND;
    else if (cur_high[7:2] == GROUP_BYTE_A[7:2] || cur_high[7:2] == GROUP_BYTE_B[7:2])
      match = MATCH_GROUP;
    else
      match = MATCH_NONE;
    // Minimum valid frame length per mode
    case (op_mode)
      OP_AUTO, OP_NON_AUTO: min_len = addr16 ? MIN_LEN_ADDR16 : MIN_LEN_ADDR8;
      OP_TRANSP:            min_len = addr16 ? MIN_LEN_TRANS1 : MIN_LEN_TRANS0;
      default:              min_len = MIN_LEN_EXT;
    endcase
    if (i_rx_byte_valid)
    begin
      if (st.byte_count == 12'h000)
        next_st.high_byte = i_rx_byte;
      if (st.byte_count != MAX_LEN)
        next_st.byte_count = st.byte_count + 12'h001;
    end
    if (i_rx_data_lost)
      next_st.lost = 1'b1;
    // Frame end latches length and status
    if (i_rx_message_end_event)
    begin
      next_st.rx_length = next_st.byte_count;
      next_st.rx_frame_status = 8'h00;
      next_st.rx_frame_status[ST_VALID] =
        !i_rx_partial_bits && (next_st.byte_count >= min_len);
      next_st.rx_frame_status[ST_OVERFLOW] = st.lost || i_rx_data_lost;
      next_st.rx_frame_status[ST_CRC] = i_rx_crc_ok;
      next_st.rx_frame_status[ST_ABORT] = i_rx_aborted;
      next_st.rx_frame_status[ST_MATCH_HI:ST_MATCH_LO] = high_recog ? match : MATCH_NONE;
      next_st.rx_frame_status[ST_CR] = addr16 ? cur_high[ADDR_CR_BIT] : 1'b0;
      next_st.byte_count = 12'h000;
      next_st.lost = 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      st <= '0;
      st.mode <= RESET_BYTE;
      st.timer_config <= RESET_BYTE;
      // Idle levels that differ from zero
      st.rts_n <= 1'b1;
      st.txd <= 1'b1;
      st.rx_serial <= 1'b1;
      st.rxd_sync <= 2'b11;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Timer ticks once per synchronised transmit clock rising edge
  protocol_timer #(
    .K_COARSE_P (K_COARSE_P),
    .K_FINE_P   (K_FINE_P)
  ) u_timer (
    .i_mclk             (i_mclk),
    .i_reset_n          (i_reset_n),
    .i_tick             (st.txclk_sync[1] && !st.txclk_sync[2]),
    .i_fine             (st.mode[MODE_TRS]),
    .i_internal         (st.mode[MODE_TIMER] && st.tx_addr_en),
    .i_count            (st.timer_config[TIMER_CNT_HI:TIMER_CNT_LO]),
    .i_period           (st.timer_config[TIMER_VAL_HI:TIMER_VAL_LO]),
    .i_start            (st.start_pulse && !st.mode[MODE_TIMER]),
    .i_stop             (st.stop_pulse),
    .i_wait_ack         (i_wait_ack),
    .o_timer_event      (o_timer_event),
    .o_send_supervisory (o_send_supervisory),
    .o_retries_done     (o_retries_done)
  );

  // Outputs below come from the state register, with s_axi_rdata zero-extended from st.rdata
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = {24'h000000, st.rdata};
  assign s_axi_rresp   = st.rresp;
  assign o_txd         = st.txd;
  assign o_rts_n       = st.rts_n;
  assign o_rx_serial   = st.rx_serial;
  assign o_operating_mode_select = st.mode[MODE_OP_HI:MODE_OP_LO];
  assign o_address_length_select = st.mode[MODE_ADDR16];
  assign o_modulo_select     = st.modulo;
  assign o_tx_address_enable = st.tx_addr_en;
  assign o_tx_address_first  = st.tx_addr_first_out;
  assign o_tx_address_second = st.tx_addr_second_out;
endmodule : hdlc_address_timer_rx_status

// file: tb/hdlc_slice_properties.sv
// Port-level properties of the HDLC address, timer and receive status slice
module hdlc_slice_properties
  import hdlc_slice_pkg::*;
#(
  parameter int K_COARSE_P = K_COARSE,
  parameter int K_FINE_P   = K_FINE
) (
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_tx_serial,
  input wire logic        o_txd,
  input wire logic        i_tx_frame_active,
  input wire logic        o_rts_n,
  input wire logic [1:0]  o_operating_mode_select,
  input wire logic        o_tx_address_enable,
  input wire logic        o_modulo_select,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        o_timer_event,
  input wire logic        o_send_supervisory
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  a_txd_copy: assert property ($past(i_reset_n) |-> o_txd == $past(i_tx_serial))
    else $error("txd does not follow the transmit bit");
  a_rts_frame: assert property ($rose(i_tx_frame_active) |=> !o_rts_n)
    else $error("rts not active at frame start");
  a_tx_enable: assert property (
    $stable(o_operating_mode_select)[*3] |->
      o_tx_address_enable == (o_operating_mode_select == OP_AUTO))
    else $error("address insertion wrong for mode");
  a_modulo_auto: assert property (
    ($stable(o_operating_mode_select) && o_operating_mode_select != OP_AUTO)[*3]
      |-> !o_modulo_select)
    else $error("modulo select outside auto mode");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_event_pulse: assert property (o_timer_event |=> !o_timer_event)
    else $error("timer event longer than a cycle");
  a_sup_auto: assert property (
    o_send_supervisory |-> o_operating_mode_select == OP_AUTO)
    else $error("supervisory send outside auto mode");
endmodule : hdlc_slice_properties

bind hdlc_address_timer_rx_status hdlc_slice_properties
  #(.K_COARSE_P(K_COARSE_P), .K_FINE_P(K_FINE_P)) u_props (.*);

// file: tb/remote_station.sv
// Behavioural remote station: free transmit clock and received frame events
module remote_station (
  input  wire logic i_mclk,
  output logic       o_tx_clk = 1'b0,
  output logic       o_rxd = 1'b1,
  output logic       o_byte_valid = 1'b0,
  output logic [7:0] o_byte = 8'h00,
  output logic       o_end = 1'b0,
  output logic       o_crc_ok = 1'b0,
  output logic       o_aborted = 1'b0,
  output logic       o_lost = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line clock unrelated in phase to the system clock
  always #29 o_tx_clk = ~o_tx_clk;

  task automatic send_frame(input logic [7:0] hi, input int n, input logic crc,
                            input logic ab, input logic lost);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_mclk);
      o_byte_valid <= 1'b1;
      o_byte       <= (i == 0) ? hi : 8'(i);
      o_rxd        <= ~o_rxd;
      o_lost       <= lost && (i == 1);
    end
    @(posedge i_mclk);
    o_byte_valid <= 1'b0;
    o_byte       <= ~o_byte;
    o_lost       <= 1'b0;
    o_end        <= 1'b1;
    o_crc_ok     <= crc;
    o_aborted    <= ab;
    @(posedge i_mclk);
    o_end     <= 1'b0;
    o_crc_ok  <= ~crc;
    o_aborted <= ~ab;
    o_rxd     <= 1'b1;
  endtask : send_frame
endmodule : remote_station

// file: tb/hdlc_address_timer_rx_status_bench.sv
// Self-checking bench for the HDLC address, timer and receive status slice
module hdlc_address_timer_rx_status_bench import hdlc_slice_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_mclk = 1'b0, i_reset_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        i_bus_config = 1'b0, i_tx_serial = 1'b1, i_tx_frame_active = 1'b0;
  logic        i_tx_is_command = 1'b0, i_wait_ack = 1'b0, i_rx_partial_bits = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, o_operating_mode_select;
  logic [7:0]  o_tx_address_first, o_tx_address_second, i_rx_byte;
  logic        o_txd, o_rts_n, o_rx_serial, o_address_length_select, o_modulo_select;
  logic        o_tx_address_enable, o_timer_event, o_send_supervisory, o_retries_done;
  logic        i_tx_clk, i_rxd, i_rx_byte_valid, i_rx_message_end_event;
  logic        i_rx_crc_ok, i_rx_aborted, i_rx_data_lost;
  int          mismatches = 0, compares = 0, cycles = 0, ne, ns, nd, fe;
  logic [12:0] pins [6] = '{13'h003, 13'h009, 13'h085, 13'h097, 13'h022, 13'h027};
  logic [30:0] frames [4] = '{{8'h10, 12'd5, 3'b100, 8'ha8}, {8'h22, 12'd4, 3'b010, 8'h92},
                              {8'hfe, 12'd3, 3'b101, 8'h66}, {8'h80, 12'd300, 3'b100, 8'hac}};
  logic [2:0]  ext_cnt [3] = '{3'h0, 3'h1, 3'h7};

  hdlc_address_timer_rx_status #(.K_COARSE_P(4), .K_FINE_P(2)) DUT (.*);

  remote_station stn (
    .i_mclk       (i_mclk),
    .o_tx_clk     (i_tx_clk),
    .o_rxd        (i_rxd),
    .o_byte_valid (i_rx_byte_valid),
    .o_byte       (i_rx_byte),
    .o_end        (i_rx_message_end_event),
    .o_crc_ok     (i_rx_crc_ok),
    .o_aborted    (i_rx_aborted),
    .o_lost       (i_rx_data_lost)
  );

  initial
  begin
    forever #4 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge i_mclk);
    s_axi_awaddr  <= {22'h0, ix, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge i_mclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] ix, input logic [7:0] ed, input logic [1:0] er = RESP_OKAY);
    @(posedge i_mclk);
    s_axi_araddr  <= {22'h0, ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge i_mclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, {24'h0, ed});
    check(32'(s_axi_rresp), 32'(er));
  endtask : rd

  task automatic count_ev(input int len, output int ne, ns, nd, fe);
    ne = 0;
    ns = 0;
    nd = 0;
    fe = len;
    for (int i = 0; i < len; i++)
    begin
      @(posedge i_mclk);
      if (o_timer_event === 1'b1 && ne == 0)
        fe = i;
      ne += int'(o_timer_event === 1'b1);
      ns += int'(o_send_supervisory === 1'b1);
      nd += int'(o_retries_done === 1'b1);
    end
  endtask : count_ev

  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(IDX_TIMER_CONFIG, RESET_BYTE);
    rd(8'h3f, 8'h00, RESP_DECERR);
    wr(8'h3f, 8'h5a, RESP_DECERR);
    wr(IDX_TIMER_CONFIG, 8'hb3);
    rd(IDX_TIMER_CONFIG, 8'hb3);
    rd(IDX_TX_ADDR_FIRST, 8'h00);
    $display("register access test done");
    foreach (pins[i])
    begin
      wr(IDX_MODE, pins[i][12:5]);
      {i_bus_config, i_tx_frame_active, i_tx_serial} <= pins[i][4:2];
      repeat (4) @(posedge i_mclk);
      check(32'(o_rts_n), 32'(pins[i][1]));
      check(32'(o_rx_serial), 32'(pins[i][0]));
      check(32'(o_txd), 32'(i_tx_serial));
    end
    i_bus_config <= 1'b0;
    $display("pin control test done");
    wr(IDX_RX_HIGH_SECOND, 8'h22);
    wr(IDX_TX_ADDR_SECOND, 8'h55);
    for (int m = 0; m < 4; m++)
    begin
      wr(IDX_MODE, {m[1:0], 6'h20});
      repeat (3) @(posedge i_mclk);
      check(32'(o_operating_mode_select), 32'(m[1:0]));
      check(32'(o_address_length_select), 32'h1);
      check(32'(o_tx_address_enable), 32'(m == 0));
      check(32'(o_modulo_select), 32'(m == 0));
    end
    wr(IDX_MODE, 8'h20);
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_RX_HIGH_FIRST, {6'h04, c[1], 1'b0});
      wr(IDX_TX_ADDR_FIRST, 8'h40);
      i_tx_is_command <= c[0];
      repeat (3) @(posedge i_mclk);
      check(32'(o_tx_address_first), 32'({6'h10, c[1] ~^ c[0], 1'b0}));
      check(32'(o_tx_address_second), 32'h55);
    end
    $display("mode and address test done");
    foreach (frames[i])
    begin
      stn.send_frame(frames[i][30:23], int'(frames[i][22:11]), frames[i][10],
                     frames[i][9], frames[i][8]);
      rd(IDX_RX_FRAME_STATUS, frames[i][7:0]);
      rd(IDX_RX_LENGTH_LOW, frames[i][18:11]);
      rd(IDX_RX_LENGTH_HIGH, {4'h0, frames[i][22:19]});
    end
    wr(IDX_RX_HIGH_SECOND, 8'h12);
    i_rx_partial_bits <= 1'b1;
    stn.send_frame(8'h10, 5, 1'b1, 1'b0, 1'b0);
    rd(IDX_RX_FRAME_STATUS, 8'h28);
    $display("receive status test done");
    for (int r = 0; r < 2; r++)
    begin
      wr(IDX_MODE, {6'h00, r[0], 1'b0});
      wr(IDX_TIMER_CONFIG, 8'h03);
      wr(IDX_COMMAND, 8'h01);
      count_ev(200, ne, ns, nd, fe);
      check(32'(fe < 87), 32'(r));
    end
    for (int c = 0; c < 3; c++)
    begin
      wr(IDX_TIMER_CONFIG, {ext_cnt[c], 5'h00});
      wr(IDX_COMMAND, 8'h01);
      count_ev(150, ne, ns, nd, fe);
      check(32'(ne > 0), 32'(c != 1));
      check(32'(ne > 2), 32'(c == 2));
    end
    wr(IDX_RX_HIGH_FIRST, 8'h00);
    wr(IDX_MODE, 8'h12);
    for (int c = 0; c < 2; c++)
    begin
      wr(IDX_TIMER_CONFIG, (c == 0) ? 8'h40 : 8'he0);
      i_wait_ack <= 1'b1;
      count_ev(150, ne, ns, nd, fe);
      i_wait_ack <= 1'b0;
      check(32'((c == 0) ? ns == 2 : ns > 4), 32'h1);
      check(32'(nd), 32'(c == 0));
    end
    $display("timer test done");
    conclude();
  end
endmodule : hdlc_address_timer_rx_status_bench
